// ### jtdr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Boundary-scan controller model, drives the test link
module jtdr_ctrl_model (
  input  wire logic i_ref_clk,
  input  wire logic i_tdo,
  output var  logic o_test_clock,
  output var  logic o_tms,
  output var  logic o_tdi
);
  // Link clock stands still low outside steps
  initial begin
    o_test_clock = 1'b0;
    o_tms        = 1'b1;
    o_tdi        = 1'b0;
  end
  // One test clock period of 160 ns; mode and data change only while clock is low
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(negedge i_ref_clk);
    o_test_clock = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    tdo          = i_tdo;                        // Late sample covers the sync delay
    o_test_clock = 1'b0;
    o_tdi        = ~tdi;                         // Hold over, stale data is not kept
  endtask : step
endmodule : jtdr_ctrl_model
`default_nettype wire

// ### jtdr_pkg.sv
package jtdr_pkg;
  // ==========================================================================
  // Instruction codes, 3-bit instruction register
  // ==========================================================================
  localparam int          JTDR_IR_W       = 3;
  localparam logic [2:0]  JTDR_OP_EXTEST  = 3'h0;
  localparam logic [2:0]  JTDR_OP_HIGHZ   = 3'h2;
  localparam logic [2:0]  JTDR_OP_CLAMP   = 3'h3;
  localparam logic [2:0]  JTDR_OP_SAMPLE  = 3'h4;
  localparam logic [2:0]  JTDR_OP_IDCODE  = 3'h6;
  localparam logic [2:0]  JTDR_OP_BYPASS  = 3'h7;
  // ==========================================================================
  // Identification word layout
  // ==========================================================================
  localparam int          JTDR_ID_W       = 32;
  localparam int          JTDR_ID_MFR_LSB = 1;
  localparam int          JTDR_ID_MFR_W   = 11;
  localparam int          JTDR_ID_DEV_LSB = 12;
  localparam int          JTDR_ID_DEV_W   = 16;
  localparam int          JTDR_ID_VER_LSB = 28;
  localparam int          JTDR_ID_VER_W   = 4;
  localparam logic [31:0] JTDR_ID_RESET   = 32'h0000_0001;
  // TAP states
  typedef enum logic [3:0] {
    JTDR_TLR, JTDR_RTI, JTDR_SEL_DR, JTDR_CAP_DR, JTDR_SH_DR, JTDR_EX1_DR,
    JTDR_PA_DR, JTDR_EX2_DR, JTDR_UPD_DR, JTDR_SEL_IR, JTDR_CAP_IR,
    JTDR_SH_IR, JTDR_EX1_IR, JTDR_PA_IR, JTDR_EX2_IR, JTDR_UPD_IR
  } jtdr_state_t;
endpackage : jtdr_pkg

// ### jtdr_test_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE1] Bypass, boundary scan and identification registers are all present.
// [RULE2] Boundary register has a shift stage and a latched output per cell.
// [RULE3] Bypass register is one stage, shortest in-to-out path.
// [RULE4] Bypass is selected under BYPASS, CLAMP and HIGHZ.
// [RULE5] Identification register: 32 shift stages plus 32-bit latched output.
// [RULE6] Identification selected under IDCODE or in Test-Logic-Reset.
// [RULE7] Boundary register length is a parameter.
// [RULE8] Three-bit instruction codes: 000,010,011,100,110,111.
// [RULE9] ID word: bit0 one, 11-bit maker, 16-bit device, 4-bit version.
// [RULE10] IDCODE: capture ID in Capture-DR, shift it out in Shift-DR.
// [RULE11] HIGHZ floats outputs; CLAMP drives held boundary latch values.
module jtdr_test_regs
  import jtdr_pkg::*;
#(
  parameter int          BSR_LEN = 8,            // see [RULE7]
  parameter logic [10:0] MFR_ID  = 11'h0AA,      // Arbitrary value
  parameter logic [15:0] DEV_ID  = 16'h1234,     // Arbitrary value
  parameter logic [3:0]  VER_ID  = 4'h1          // Arbitrary value
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_clk_en,
  input  wire logic               i_test_clock_in,
  input  wire logic               i_tms,
  input  wire logic               i_tdi,
  input  wire logic [BSR_LEN-1:0] i_pin_in,
  input  wire logic [BSR_LEN-1:0] i_core_out,
  output logic                    o_tdo,
  output logic                    o_tdo_oe,
  output logic [BSR_LEN-1:0]      o_pin_out,
  output logic                    o_pin_oe,
  output logic [2:0]              o_instr,
  output logic [31:0]             o_id_latch
);
  // ==========================================================================
  // Pin synchronisers: three stages, test clock change accepted when stages 2 and 3 agree
  // ==========================================================================
  logic [2:0] tck_sync_reg, tms_sync_reg, tdi_sync_reg;
  logic       tck_level_reg;
  // Boundary cell inputs are pins too, so they get the same three-stage filter
  logic [BSR_LEN-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_level_reg;
  wire  [BSR_LEN-1:0] pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tck_sync_reg  <= 3'h0;
      tms_sync_reg  <= 3'h0;
      tdi_sync_reg  <= 3'h0;
      tck_level_reg <= 1'b0;
      pin_s1_reg    <= '0;
      pin_s2_reg    <= '0;
      pin_s3_reg    <= '0;
      pin_level_reg <= '0;
    end else if (i_clk_en) begin
      tck_sync_reg  <= {tck_sync_reg[1:0], i_test_clock_in};
      tms_sync_reg  <= {tms_sync_reg[1:0], i_tms};
      tdi_sync_reg  <= {tdi_sync_reg[1:0], i_tdi};
      if (tck_sync_reg[1] == tck_sync_reg[2])
        tck_level_reg <= tck_sync_reg[2];
      pin_s1_reg    <= i_pin_in;
      pin_s2_reg    <= pin_s1_reg;
      pin_s3_reg    <= pin_s2_reg;
      pin_level_reg <= (pin_s3_reg & pin_agree) | (pin_level_reg & ~pin_agree); // Bits in disagreement hold
    end
  end
  // Edges of the filtered test clock; TMS/TDI sampled from stage 3
  wire tck_agree = (tck_sync_reg[1] == tck_sync_reg[2]);
  wire tck_rise  = i_clk_en & tck_agree & tck_sync_reg[2] & ~tck_level_reg;
  wire tck_fall  = i_clk_en & tck_agree & ~tck_sync_reg[2] & tck_level_reg;
  wire tms_s     = tms_sync_reg[2];
  wire tdi_s     = tdi_sync_reg[2];

  // ==========================================================================
  // TAP sequencer (needed to drive the data registers)
  // ==========================================================================
  jtdr_state_t state_reg, state_next;
  always_comb begin
    case (state_reg)
      JTDR_TLR:    state_next = tms_s ? JTDR_TLR    : JTDR_RTI;
      JTDR_RTI:    state_next = tms_s ? JTDR_SEL_DR : JTDR_RTI;
      JTDR_SEL_DR: state_next = tms_s ? JTDR_SEL_IR : JTDR_CAP_DR;
      JTDR_CAP_DR: state_next = tms_s ? JTDR_EX1_DR : JTDR_SH_DR;
      JTDR_SH_DR:  state_next = tms_s ? JTDR_EX1_DR : JTDR_SH_DR;
      JTDR_EX1_DR: state_next = tms_s ? JTDR_UPD_DR : JTDR_PA_DR;
      JTDR_PA_DR:  state_next = tms_s ? JTDR_EX2_DR : JTDR_PA_DR;
      JTDR_EX2_DR: state_next = tms_s ? JTDR_UPD_DR : JTDR_SH_DR;
      JTDR_UPD_DR: state_next = tms_s ? JTDR_SEL_DR : JTDR_RTI;
      JTDR_SEL_IR: state_next = tms_s ? JTDR_TLR    : JTDR_CAP_IR;
      JTDR_CAP_IR: state_next = tms_s ? JTDR_EX1_IR : JTDR_SH_IR;
      JTDR_SH_IR:  state_next = tms_s ? JTDR_EX1_IR : JTDR_SH_IR;
      JTDR_EX1_IR: state_next = tms_s ? JTDR_UPD_IR : JTDR_PA_IR;
      JTDR_PA_IR:  state_next = tms_s ? JTDR_EX2_IR : JTDR_PA_IR;
      JTDR_EX2_IR: state_next = tms_s ? JTDR_UPD_IR : JTDR_SH_IR;
      JTDR_UPD_IR: state_next = tms_s ? JTDR_SEL_DR : JTDR_RTI;
      default:     state_next = JTDR_TLR;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      state_reg <= JTDR_TLR;
    else if (tck_rise)
      state_reg <= state_next;
  end

  // ==========================================================================
  // Register selection
  // ==========================================================================
  logic [2:0] ir_shift_reg;
  logic [2:0] ir_reg;
  wire in_tlr   = (state_reg == JTDR_TLR);
  wire sel_id   = in_tlr | (ir_reg == JTDR_OP_IDCODE);                 // see [RULE6]
  wire sel_byp  = ~sel_id & ((ir_reg == JTDR_OP_BYPASS) | (ir_reg == JTDR_OP_CLAMP)
                             | (ir_reg == JTDR_OP_HIGHZ));              // see [RULE4]
  // Unlisted codes fall back to bypass, the safe choice
  wire sel_bsr  = ~sel_id & ((ir_reg == JTDR_OP_EXTEST) | (ir_reg == JTDR_OP_SAMPLE));
  wire sel_byp_all = ~sel_id & ~sel_bsr;
  wire cap_dr   = tck_rise & (state_reg == JTDR_CAP_DR);
  wire sh_dr    = tck_rise & (state_reg == JTDR_SH_DR);
  wire upd_dr   = tck_fall & (state_reg == JTDR_UPD_DR);
  wire [31:0] id_word = {VER_ID, DEV_ID, MFR_ID, 1'b1};                 // see [RULE9]

  // ==========================================================================
  // Instruction register; capture loads 01 per standard
  // ==========================================================================
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ir_shift_reg <= 3'h0;
      ir_reg       <= JTDR_OP_IDCODE;
    end else if (i_clk_en) begin
      if (tck_rise && state_reg == JTDR_CAP_IR)
        ir_shift_reg <= 3'h1;
      else if (tck_rise && state_reg == JTDR_SH_IR)
        ir_shift_reg <= {tdi_s, ir_shift_reg[2:1]};
      if (in_tlr)
        ir_reg <= JTDR_OP_IDCODE;                                       // see [RULE6]
      else if (tck_fall && state_reg == JTDR_UPD_IR)
        ir_reg <= ir_shift_reg;                                         // see [RULE8]
    end
  end

  // ==========================================================================
  // Data registers: bypass, identification, boundary scan
  // ==========================================================================
  logic               byp_reg;
  logic [31:0]        id_shift_reg;
  logic [BSR_LEN-1:0] bsr_shift_reg;
  logic [BSR_LEN-1:0] bsr_latch_reg;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      byp_reg       <= 1'b0;
      id_shift_reg  <= JTDR_ID_RESET;
      bsr_shift_reg <= '0;
    end else begin
      if (cap_dr)
        byp_reg <= 1'b0;
      else if (sh_dr && sel_byp_all)
        byp_reg <= tdi_s;                                               // see [RULE3]
      if (cap_dr && sel_id)
        id_shift_reg <= id_word;                                        // see [RULE10]
      else if (sh_dr && sel_id)
        id_shift_reg <= {tdi_s, id_shift_reg[31:1]};                    // see [RULE5]
      if (cap_dr && sel_bsr)
        bsr_shift_reg <= pin_level_reg;                                 // see [RULE2]
      else if (sh_dr && sel_bsr)
        bsr_shift_reg <= {tdi_s, bsr_shift_reg[BSR_LEN-1:1]};
    end
  end

  // Latched outputs change only on Update-DR, so shifting never disturbs pins
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bsr_latch_reg <= '0;
      o_id_latch    <= JTDR_ID_RESET;
    end else if (upd_dr) begin
      if (sel_bsr)
        bsr_latch_reg <= bsr_shift_reg;                                 // see [RULE2]
      if (sel_id)
        o_id_latch <= id_shift_reg;                                     // see [RULE5]
    end
  end

  // ==========================================================================
  // Serial output on falling test clock edge; pin drive per instruction
  // ==========================================================================
  wire tdo_bit = (state_reg == JTDR_SH_IR) ? ir_shift_reg[0] :
                 sel_id  ? id_shift_reg[0] :
                 sel_bsr ? bsr_shift_reg[0] : byp_reg;                  // see [RULE1]
  wire shifting = (state_reg == JTDR_SH_DR) | (state_reg == JTDR_SH_IR);
  wire test_mode = (ir_reg == JTDR_OP_EXTEST) | (ir_reg == JTDR_OP_CLAMP);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tdo     <= 1'b0;
      o_tdo_oe  <= 1'b0;
      o_pin_out <= '0;
      o_pin_oe  <= 1'b1;
      o_instr   <= JTDR_OP_IDCODE;
    end else if (i_clk_en) begin
      if (tck_fall) begin
        o_tdo    <= tdo_bit;
        o_tdo_oe <= shifting;
      end
      o_pin_out <= test_mode ? bsr_latch_reg : i_core_out;              // see [RULE11]
      o_pin_oe  <= (ir_reg != JTDR_OP_HIGHZ);                           // see [RULE11]
      o_instr   <= ir_reg;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_cap_id;
    cap_dr && sel_id;
  endsequence
  a_id_capture: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE10]
    s_cap_id |=> (id_shift_reg == id_word)) else $error("id not captured");
  a_id_lsb_one: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE9]
    s_cap_id |=> (id_shift_reg[0] == 1'b1)
                 && (id_shift_reg[JTDR_ID_MFR_LSB +: JTDR_ID_MFR_W] == MFR_ID)
                 && (id_shift_reg[JTDR_ID_DEV_LSB +: JTDR_ID_DEV_W] == DEV_ID)
                 && (id_shift_reg[JTDR_ID_VER_LSB +: JTDR_ID_VER_W] == VER_ID))
    else $error("id fields misplaced");
  a_tlr_selects_id: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE6]
    (in_tlr && i_clk_en) |=> ir_reg == JTDR_OP_IDCODE) else $error("tlr did not force idcode");
  a_bypass_sel: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE4]
    (!sel_id && state_reg != JTDR_SH_IR && (ir_reg == JTDR_OP_CLAMP || ir_reg == JTDR_OP_HIGHZ
     || ir_reg == JTDR_OP_BYPASS)) |-> (tdo_bit == byp_reg)) else $error("bypass not on serial path");
  a_bypass_shift: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE3]
    (sh_dr && sel_byp) |=> byp_reg == $past(tdi_s)) else $error("bypass shift wrong");
  a_highz_float: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE11]
    (i_clk_en && ir_reg == JTDR_OP_HIGHZ) |=> !o_pin_oe) else $error("highz drives pins");
  a_clamp_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE11]
    (i_clk_en && ir_reg == JTDR_OP_CLAMP) |=> o_pin_out == $past(bsr_latch_reg))
    else $error("clamp output wrong");
  a_bsr_latch_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE2]
    !upd_dr |=> $stable(bsr_latch_reg)) else $error("bsr latch moved");
  a_id_shift_in: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE5]
    (sh_dr && sel_id) |=> id_shift_reg[31] == $past(tdi_s)) else $error("id shift wrong");
endmodule : jtdr_test_regs
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the test data registers
module testbench;
  import jtdr_pkg::*;
  localparam logic [10:0] TB_MFR = 11'h155;      // Arbitrary value
  localparam logic [15:0] TB_DEV = 16'hC0DE;     // Arbitrary value
  localparam logic [3:0]  TB_VER = 4'h9;         // Arbitrary value
  localparam logic [31:0] EXP_ID = {TB_VER, TB_DEV, TB_MFR, 1'b1};
  // Packed list of codes that must end on the bypass path, first code in the low bits
  localparam logic [14:0] BYP_CODES = {3'h5, 3'h1, JTDR_OP_HIGHZ, JTDR_OP_CLAMP, JTDR_OP_BYPASS};
  logic        ref_clk, rst_n, clk_en, test_clock, tms, tdi, tdo, tdo_oe, pin_oe;
  logic [7:0]  pin_in, core_out, pin_out;
  logic [2:0]  instr;
  logic [31:0] id_latch;
  int          fail_count, total_checks;
  jtdr_test_regs #(.BSR_LEN(8), .MFR_ID(TB_MFR), .DEV_ID(TB_DEV), .VER_ID(TB_VER)) u_jtdr_test_regs (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_test_clock_in(test_clock),
    .i_tms(tms), .i_tdi(tdi), .i_pin_in(pin_in), .i_core_out(core_out), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_instr(instr), .o_id_latch(id_latch));
  jtdr_ctrl_model u_jtdr_ctrl_model (
    .i_ref_clk(ref_clk), .i_tdo(tdo), .o_test_clock(test_clock), .o_tms(tms), .o_tdi(tdi));
  // 50 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic st(input logic m, input logic d, output logic b);
    u_jtdr_ctrl_model.step(m, d, b);
  endtask : st
  // From Run-Test-Idle through a data scan and back; LSB goes first
  task automatic shift_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    st(1'b1, 1'b0, b);
    st(1'b0, 1'b0, b);
    st(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      st(i == n - 1, din[i], b);
      dout[i] = b;
      if (i == 0) check("tdo_oe_shift", 32'(tdo_oe), 32'h1);
    end
    st(1'b1, 1'b0, b);
    st(1'b0, 1'b0, b);
    check("tdo_oe_idle", 32'(tdo_oe), 32'h0);
  endtask : shift_dr
  task automatic shift_ir(input logic [2:0] code);
    logic b;
    st(1'b1, 1'b0, b);
    st(1'b1, 1'b0, b);
    st(1'b0, 1'b0, b);
    st(1'b0, 1'b0, b);
    for (int i = 0; i < 3; i++) st(i == 2, code[i], b);
    st(1'b1, 1'b0, b);
    st(1'b0, 1'b0, b);
    check("instr", 32'(instr), 32'(code));
  endtask : shift_ir
  task automatic t_idcode;
    logic [31:0] d;
    logic        b;
    check("instr_reset", 32'(instr), 32'(JTDR_OP_IDCODE));
    st(1'b0, 1'b0, b);
    shift_dr(32, 32'h5A5A_C33C, d);
    check("id_shift", d, EXP_ID);
    // The latch takes whatever was shifted in, not the captured word
    check("id_latch", id_latch, 32'h5A5A_C33C);
    $display("t_idcode done");
  endtask : t_idcode
  // Bypass delays by one stage and captures zero; unlisted codes fall back to bypass
  task automatic t_bypass;
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      shift_ir(BYP_CODES[i*3 +: 3]);
      shift_dr(8, 32'hA5, d);
      check("bypass_out", d, 32'h4A);
      check("pin_oe", 32'(pin_oe), 32'(BYP_CODES[i*3 +: 3] != JTDR_OP_HIGHZ));
    end
    $display("t_bypass done");
  endtask : t_bypass
  task automatic t_boundary;
    logic [31:0] d;
    logic        b;
    shift_ir(JTDR_OP_SAMPLE);
    shift_dr(8, 32'h96, d);
    check("bsr_capture", d, 32'h3C);
    check("pins_normal", 32'(pin_out), 32'h5A);
    shift_ir(JTDR_OP_EXTEST);
    check("pins_extest", 32'(pin_out), 32'h96);
    shift_ir(JTDR_OP_CLAMP);
    core_out = 8'hC3;
    shift_dr(8, 32'h0, d);
    check("pins_clamp", 32'(pin_out), 32'h96);
    for (int i = 0; i < 5; i++) st(1'b1, 1'b0, b);
    check("instr_tlr", 32'(instr), 32'(JTDR_OP_IDCODE));
    check("pins_tlr", 32'(pin_out), 32'hC3);
    $display("t_boundary done");
  endtask : t_boundary
  // Clock enable freeze, then a reset in mid-run with the boundary latch on the pins
  task automatic t_reset;
    logic [31:0] d;
    logic        b;
    clk_en   = 1'b0;
    core_out = 8'h11;
    repeat (10) @(negedge ref_clk);
    check("pins_frozen", 32'(pin_out), 32'hC3);
    clk_en = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("pins_resumed", 32'(pin_out), 32'h11);
    st(1'b0, 1'b0, b);
    shift_ir(JTDR_OP_EXTEST);
    check("pins_extest2", 32'(pin_out), 32'h96);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("rst_instr", 32'(instr), 32'(JTDR_OP_IDCODE));
    check("rst_pins", 32'(pin_out), 32'h0);
    check("rst_pin_oe", 32'(pin_oe), 32'h1);
    check("rst_tdo_oe", 32'(tdo_oe), 32'h0);
    check("rst_id_latch", id_latch, JTDR_ID_RESET);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("pins_after_rst", 32'(pin_out), 32'h11);
    st(1'b0, 1'b0, b);
    shift_dr(32, 32'h0, d);
    check("id_after_rst", d, EXP_ID);
    $display("t_reset done");
  endtask : t_reset
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // Main sequence, inputs change on the falling edge
  initial begin
    fail_count   = 0;
    total_checks = 0;
    rst_n        = 1'b0;
    clk_en       = 1'b1;
    pin_in       = 8'h3C;
    core_out     = 8'h5A;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    t_idcode();
    t_bypass();
    t_boundary();
    t_reset();
    report_and_stop();
  end
  // About ten times the expected run length of roughly 41 us
  initial begin
    #400000;
    fail_count++;
    $display("Error watchdog expected done seen hang");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
